// File: inc/tscsm_pkg.sv
// Purpose: Shared constants for the timestamp clock synchronisation unit.
// Assumes: 50 MHz system clock, 8-bit register address, 32-bit register data.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package tscsm_pkg;

   // Clock and synthesised time base rates.
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned SYN_HZ       = 67_108_864;
   localparam logic [26:0] DDS_STEP     = 27'(SYN_HZ - CLK_HZ);
   localparam logic [26:0] DDS_MOD      = 27'(CLK_HZ);
   localparam int          FRAC_W       = 26;
   localparam logic [27:0] FRAC_ONE     = 28'h4000000;
   localparam logic [25:0] FRAC_HALF    = 26'h2000000;
   // Internal once-per-second pulse stays high for the first 100 ms of a second.
   localparam int unsigned PPS_HIGH_MS  = 100;
   localparam logic [25:0] PPS_HIGH_FRAC = 26'((SYN_HZ / 1000) * PPS_HIGH_MS);
   // Nanoseconds per tick in Q8: 1e9 / 2^26 * 256.
   localparam logic [11:0] NS_PER_TICK_Q8 = 12'hee7;
   localparam int          NS_SHIFT     = 8;

   // Health threshold in nanoseconds after reset.
   localparam int unsigned THRESH_NS    = 596;
   localparam logic [31:0] THRESH_RST   = 32'(THRESH_NS);
   // Pulse window: one second with a tolerance of 1 ms either side.
   localparam int unsigned ONE_SEC_CYC  = CLK_HZ;
   localparam int unsigned TOL_US       = 1000;
   localparam int unsigned TOL_CYC      = (CLK_HZ / 1_000_000) * TOL_US;

   // Register offsets.
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_CMD       = 8'h04;
   localparam logic [7:0] REG_HOST_SEC  = 8'h08;
   localparam logic [7:0] REG_HOST_FRAC = 8'h0c;
   localparam logic [7:0] REG_CORR      = 8'h10;
   localparam logic [7:0] REG_THRESH    = 8'h14;
   localparam logic [7:0] REG_STATUS    = 8'h18;
   localparam logic [7:0] REG_FAILS     = 8'h1c;
   localparam logic [7:0] REG_RESYNCS   = 8'h20;
   localparam logic [7:0] REG_TOTAL     = 8'h24;
   localparam logic [7:0] REG_BAD       = 8'h28;
   localparam logic [7:0] REG_MISSED    = 8'h2c;
   localparam logic [7:0] REG_LONGEST   = 8'h30;
   localparam logic [7:0] REG_TIME_SEC  = 8'h34;
   localparam logic [7:0] REG_TIME_FRAC = 8'h38;
   localparam logic [7:0] REG_PHASE     = 8'h3c;

   // Field positions.
   localparam int CTRL_IN_LSB  = 0;
   localparam int CTRL_OUT_LSB = 4;
   localparam int CMD_SET      = 0;
   localparam int CMD_RESET    = 1;
   localparam int CMD_CLEAR    = 2;

   // Input selector codes.
   typedef enum logic [2:0] {
      IN_NONE = 3'h0, IN_SERIAL = 3'h1, IN_HOST = 3'h2, IN_OVER = 3'h3, IN_AUX = 3'h4
   } tscsm_in_sel_t;

   // Output selector codes.
   typedef enum logic [2:0] {
      OUT_NONE = 3'h0, OUT_REPEAT = 3'h1, OUT_LOOP = 3'h2, OUT_HOST = 3'h3, OUT_MASTER = 3'h4
   } tscsm_out_sel_t;

endpackage

// File: verilog/tscsm_pulse_in.sv
// Purpose: Synchronise an external pulse level and flag its rising edge.
// Assumes: Input is asynchronous to clk_i.
// Notes:   The level moves only once the second and third stages agree.
`timescale 1ns/10ps
module tscsm_pulse_in (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic pulse_i,
   output logic      level_o,
   output logic      rise_o
);
   import tscsm_pkg::*;

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Three-stage synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pulse_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Agreed level and a one-cycle rising-edge flag.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_o <= 1'b0;
         rise_o  <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         if (s2_ff == s3_ff) begin
            level_o <= s3_ff;
            rise_o  <= s3_ff & ~level_o;
         end
      end
   end
endmodule // tscsm_pulse_in

// File: verilog/tscsm_time_ctr.sv
// Purpose: Local time counter advanced by a synthesised tick rate.
// Assumes: Tick rate lies between one and two ticks per system clock.
// Notes:   Fraction counts 2^-26 s; adjustment adds a signed tick offset.
`timescale 1ns/10ps
module tscsm_time_ctr (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        load_i,
   input  wire logic [31:0] load_sec_i,
   input  wire logic [25:0] load_frac_i,
   input  wire logic        adj_i,
   input  wire logic [27:0] adj_delta_i,
   output logic      [31:0] sec_o,
   output logic      [25:0] frac_o,
   output logic             second_o
);
   import tscsm_pkg::*;

   logic [26:0] acc_ff;
   logic [26:0] acc_sum;
   logic [27:0] ticks;
   logic [27:0] frac_sum;

   ////////////////////////////////////////////////////////////////////////////
   // Phase accumulator makes one or two ticks per clock at the synthesised rate.
   always_comb begin
      acc_sum = acc_ff + DDS_STEP;
      ticks   = (acc_sum >= DDS_MOD) ? 28'h2 : 28'h1;
      frac_sum = {2'b00, frac_o} + ticks + (adj_i ? adj_delta_i : 28'h0);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         acc_ff <= 27'h0;
      end else begin
         acc_ff <= (acc_sum >= DDS_MOD) ? acc_sum - DDS_MOD : acc_sum;
      end
   end

   // Load wins over advance; a carry or borrow moves the seconds.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sec_o    <= 32'h0;
         frac_o   <= 26'h0;
         second_o <= 1'b0;
      end else if (load_i) begin
         sec_o    <= load_sec_i;
         frac_o   <= load_frac_i;
         second_o <= 1'b0;
      end else if (frac_sum[27]) begin
         sec_o    <= sec_o - 32'h1;
         frac_o   <= frac_sum[25:0];
         second_o <= 1'b0;
      end else if (frac_sum >= FRAC_ONE) begin
         sec_o    <= sec_o + 32'h1;
         frac_o   <= frac_sum[25:0];
         second_o <= 1'b1;
      end else begin
         frac_o   <= frac_sum[25:0];
         second_o <= 1'b0;
      end
   end
endmodule // tscsm_time_ctr

// File: verilog/tscsm_top.sv
// Purpose: Timestamp clock synchronisation unit with input and output selectors.
// Assumes: Host registers on a plain strobe port; read data one cycle later.
// Notes:   Pulse input and output use circuit A of the sync connector.
`timescale 1ns/10ps

// Function
// - Time counter loads host time, then free-runs from the crystal.
// - Accept a pulse-per-second input on the serial differential pin.
// - Drive a sync output other cards can use as reference.
// - Reset selects serial pulse input and disables the sync output.
// - Host-reference input disciplines the counter from host corrections.
// - No-input, host and auxiliary settings exist; host unused; no input free-runs.
// - Repeat setting copies the received pulse onto the sync output.
// - Loop setting drives the selected input onto the sync output.
// - Master setting drives the internal once-per-second pulse out.
// - Host-reference input and master output may run together.
// - Set command overwrites time with host time, selectors kept.
// - Full clock reset reloads host time, serial input, output off.
// - Synced only while phase error within threshold; count failures, resyncs.
// - Count pulses, bad pulses, missed pulses and longest missed run; clearable.
// - Counter advances at 67108864 Hz synthesised from the crystal.
// - Pulse uses circuit A; valid reference pulse locks automatically.
module tscsm_top #(
   parameter int unsigned ONE_SEC = tscsm_pkg::ONE_SEC_CYC,
   parameter int unsigned TOL     = tscsm_pkg::TOL_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        pulse_a_i,
   input  wire logic        aux_pulse_i,
   output logic             sync_a_o,
   output logic             sync_a_oe_o,
   output logic             synced_o
);
   import tscsm_pkg::*;

   tscsm_in_sel_t  in_sel_ff,  nxt_in_sel;
   tscsm_out_sel_t out_sel_ff, nxt_out_sel;
   tscsm_in_sel_t  pend_in_ff;
   tscsm_out_sel_t pend_out_ff;
   logic [31:0] host_sec_ff;
   logic [25:0] host_frac_ff;
   logic [31:0] thresh_ff;
   logic [31:0] fails_ff, resyncs_ff, total_ff, bad_ff, missed_ff;
   logic [31:0] run_ff, longest_ff;
   logic [31:0] phase_ns_ff;
   logic [31:0] since_ff;
   logic        first_ff;
   logic        wr_cmd, cmd_set, cmd_reset, cmd_clear, corr_wr;
   logic        ser_level, ser_rise, aux_level, aux_rise;
   logic [31:0] sec;
   logic [25:0] frac;
   logic        second;
   logic        ref_rise, ref_event, too_early, expired, pps_level, in_level;
   logic [27:0] err, adj_delta;
   logic [37:0] err_ns;

   // Magnitude of a signed tick error converted to nanoseconds.
   function automatic logic [37:0] ticks_to_ns(input logic [27:0] e);
      logic [25:0] mag;
      logic [37:0] prod;
      mag  = e[27] ? 26'(-e) : e[25:0];
      prod = 38'(mag) * 38'(NS_PER_TICK_Q8);
      return prod >> NS_SHIFT;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input conditioning for the circuit A pulse and the auxiliary pulse.
   tscsm_pulse_in u_ser (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .pulse_i (pulse_a_i),
      .level_o (ser_level),
      .rise_o  (ser_rise)
   );

   tscsm_pulse_in u_aux (
      .clk_i   (clk_i),
      .arst_n_i(arst_n_i),
      .pulse_i (aux_pulse_i),
      .level_o (aux_level),
      .rise_o  (aux_rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command decode; commands are one-cycle pulses from a write.
   assign wr_cmd    = wr_i && (addr_i == REG_CMD);
   assign cmd_set   = wr_cmd && wdata_i[CMD_SET];
   assign cmd_reset = wr_cmd && wdata_i[CMD_RESET];
   assign cmd_clear = wr_cmd && wdata_i[CMD_CLEAR];
   assign corr_wr   = wr_i && (addr_i == REG_CORR) && (in_sel_ff == IN_OVER);

   // Phase error is the signed distance of the counter from the second edge.
   assign err = (frac >= FRAC_HALF) ? ({2'b00, frac} - FRAC_ONE) : {2'b00, frac};

   // Reference edge from the chosen source; none and host settings give none.
   always_comb begin
      case (in_sel_ff)
         IN_SERIAL: ref_rise = ser_rise;
         IN_AUX:    ref_rise = aux_rise;
         default:   ref_rise = 1'b0;
      endcase
   end

   assign too_early = !first_ff && (since_ff < 32'(ONE_SEC - TOL));
   assign expired   = (in_sel_ff == IN_SERIAL || in_sel_ff == IN_AUX)
                      && (since_ff >= 32'(ONE_SEC + TOL));
   assign ref_event = ref_rise && !too_early;
   // Pulse correction pulls the fraction to zero; host correction adds its offset.
   assign adj_delta = corr_wr ? wdata_i[27:0] : 28'(-err);
   assign err_ns    = corr_wr ? ticks_to_ns(wdata_i[27:0]) : ticks_to_ns(err);

   ////////////////////////////////////////////////////////////////////////////
   // Local time counter.
   tscsm_time_ctr u_ctr (
      .clk_i      (clk_i),
      .arst_n_i   (arst_n_i),
      .load_i     (cmd_set || cmd_reset),
      .load_sec_i (host_sec_ff),
      .load_frac_i(host_frac_ff),
      .adj_i      (ref_event || corr_wr),
      .adj_delta_i(adj_delta),
      .sec_o      (sec),
      .frac_o     (frac),
      .second_o   (second)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Host time staging, threshold and pending selectors.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         host_sec_ff  <= 32'h0;
         host_frac_ff <= 26'h0;
         thresh_ff    <= THRESH_RST;
      end else if (wr_i) begin
         if (addr_i == REG_HOST_SEC) host_sec_ff <= wdata_i;
         if (addr_i == REG_HOST_FRAC) host_frac_ff <= wdata_i[25:0];
         if (addr_i == REG_THRESH) thresh_ff <= wdata_i;
      end
   end

   // Selector writes wait for the second edge so no partial pulse goes out.
   always_comb begin
      nxt_in_sel  = in_sel_ff;
      nxt_out_sel = out_sel_ff;
      if (cmd_reset) begin
         nxt_in_sel  = IN_SERIAL;
         nxt_out_sel = OUT_NONE;
      end else if (second) begin
         nxt_in_sel  = pend_in_ff;
         nxt_out_sel = pend_out_ff;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_in_ff  <= IN_SERIAL;
         pend_out_ff <= OUT_NONE;
         in_sel_ff   <= IN_SERIAL;
         out_sel_ff  <= OUT_NONE;
      end else begin
         in_sel_ff  <= nxt_in_sel;
         out_sel_ff <= nxt_out_sel;
         if (cmd_reset) begin
            pend_in_ff  <= IN_SERIAL;
            pend_out_ff <= OUT_NONE;
         end else if (wr_i && addr_i == REG_CTRL) begin
            // Selectors are independent, so host input and master output coexist.
            pend_in_ff  <= tscsm_in_sel_t'(wdata_i[CTRL_IN_LSB +: 3]);
            pend_out_ff <= tscsm_out_sel_t'(wdata_i[CTRL_OUT_LSB +: 3]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse window timing and missed-pulse accounting.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         since_ff <= 32'h0;
         first_ff <= 1'b1;
      end else if (nxt_in_sel != in_sel_ff || ref_event) begin
         since_ff <= 32'h0;
         first_ff <= !ref_event;
      end else if (expired) begin
         since_ff <= 32'(TOL); // Next miss is one second later.
      end else begin
         since_ff <= since_ff + 32'h1;
      end
   end

   // Statistics; an increment in the clearing cycle survives: counters restart at one, longest_ff at run_ff + 1.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         total_ff   <= 32'h0;
         bad_ff     <= 32'h0;
         missed_ff  <= 32'h0;
         run_ff     <= 32'h0;
         longest_ff <= 32'h0;
      end else begin
         total_ff  <= (cmd_clear ? 32'h0 : total_ff) + 32'(ref_rise || corr_wr);
         bad_ff    <= (cmd_clear ? 32'h0 : bad_ff) + 32'(ref_rise && too_early);
         missed_ff <= (cmd_clear ? 32'h0 : missed_ff) + 32'(expired);
         if (ref_event) begin
            run_ff <= 32'h0;
         end else if (expired) begin
            run_ff <= run_ff + 32'h1;
         end
         if (expired && (cmd_clear || run_ff + 32'h1 > longest_ff)) begin
            longest_ff <= run_ff + 32'h1;
         end else if (cmd_clear) begin
            longest_ff <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock health: synced only while error stays within the threshold.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         synced_o    <= 1'b0;
         fails_ff    <= 32'h0;
         resyncs_ff  <= 32'h0;
         phase_ns_ff <= 32'h0;
      end else begin
         if (cmd_clear) begin
            fails_ff   <= 32'h0;
            resyncs_ff <= 32'h0;
         end
         if (ref_event || corr_wr) begin
            phase_ns_ff <= err_ns[31:0];
            if (err_ns > 38'(thresh_ff)) begin
               synced_o <= 1'b0;
               fails_ff <= (cmd_clear ? 32'h0 : fails_ff) + 32'h1;
            end else begin
               synced_o <= 1'b1;
               if (!synced_o) begin
                  resyncs_ff <= (cmd_clear ? 32'h0 : resyncs_ff) + 32'h1;
               end
            end
         end else if (expired || in_sel_ff == IN_NONE || in_sel_ff == IN_HOST) begin
            synced_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sync output selection, registered straight onto the pins.
   assign pps_level = (frac < PPS_HIGH_FRAC);

   always_comb begin
      case (in_sel_ff)
         IN_SERIAL: in_level = ser_level;
         IN_AUX:    in_level = aux_level;
         IN_OVER:   in_level = pps_level;
         default:   in_level = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_a_o    <= 1'b0;
         sync_a_oe_o <= 1'b0;
      end else begin
         case (out_sel_ff)
            OUT_REPEAT: begin
               sync_a_o    <= ser_level;
               sync_a_oe_o <= 1'b1;
            end
            OUT_LOOP: begin
               sync_a_o    <= in_level;
               sync_a_oe_o <= 1'b1;
            end
            OUT_MASTER: begin
               sync_a_o    <= pps_level;
               sync_a_oe_o <= 1'b1;
            end
            default: begin
               sync_a_o    <= 1'b0; // Host-driven setting is unused; treated as none.
               sync_a_oe_o <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port; data stands only in the cycle after the strobe.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= 32'h0;
      end else if (!rd_i) begin
         rdata_o <= 32'h0;
      end else begin
         case (addr_i)
            REG_CTRL:      rdata_o <= {25'h0, pend_out_ff, 1'b0, pend_in_ff};
            REG_HOST_SEC:  rdata_o <= host_sec_ff;
            REG_HOST_FRAC: rdata_o <= {6'h0, host_frac_ff};
            REG_THRESH:    rdata_o <= thresh_ff;
            REG_STATUS:    rdata_o <= {24'h0, out_sel_ff, in_sel_ff, 1'b0, synced_o};
            REG_FAILS:     rdata_o <= fails_ff;
            REG_RESYNCS:   rdata_o <= resyncs_ff;
            REG_TOTAL:     rdata_o <= total_ff;
            REG_BAD:       rdata_o <= bad_ff;
            REG_MISSED:    rdata_o <= missed_ff;
            REG_LONGEST:   rdata_o <= longest_ff;
            REG_TIME_SEC:  rdata_o <= sec;
            REG_TIME_FRAC: rdata_o <= {6'h0, frac};
            REG_PHASE:     rdata_o <= phase_ns_ff;
            default:       rdata_o <= 32'h0;
         endcase
      end
   end
endmodule // tscsm_top

// File: tb/tscsm_pps_src.sv
// Purpose: Pulse-per-second source standing in for the time receiver.
// Assumes: The differential pair is already received onto one line.
// Notes:   A skipped pulse leaves the line low for that whole second.
`timescale 1ns/10ps
module tscsm_pps_src #(
   parameter int unsigned PERIOD = 2000,
   parameter int unsigned WIDTH  = 10
) (
   input  wire logic clk_i,
   input  wire logic en_i,
   input  wire logic skip_i,
   output logic      pulse_o
);
   int unsigned cnt_ff;

   // The pulse leads each second; a disabled source keeps the line low.
   always_ff @(posedge clk_i) begin
      if (!en_i) begin
         cnt_ff  <= 0;
         pulse_o <= 1'b0;
      end else begin
         cnt_ff  <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
         pulse_o <= (cnt_ff < WIDTH) && !skip_i;
      end
   end
endmodule // tscsm_pps_src

// File: tb/tscsm_chk.sv
// Purpose: Port assertions for the clock sync unit.
// Assumes: Read data stand only in the cycle after the strobe.
// Notes:   Shadows follow host writes only, never design state.
`timescale 1ns/10ps
module tscsm_chk
   import tscsm_pkg::*;
#(
   parameter int unsigned ONE_SEC = 2000,
   parameter int unsigned TOL     = 100
) (
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        pulse_a_i,
   input wire logic        aux_pulse_i,
   input wire logic        sync_a_o,
   input wire logic        sync_a_oe_o,
   input wire logic        synced_o
);
   logic [31:0] thr_ff;
   logic [31:0] gap_ff;
   logic [6:0]  ctl_ff;
   logic [3:0]  evt_ff;
   logic        pa_ff;
   logic        ax_ff;
   logic        evt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   ////////////////////////////////////////////////////////////
   // A reference event is a pin edge or a host correction.
   assign evt = (pulse_a_i & ~pa_ff) | (aux_pulse_i & ~ax_ff) | (wr_i & (addr_i == REG_CORR));
   // The gap counter saturates so a long idle cannot wrap it back to zero.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         thr_ff <= THRESH_RST;
         ctl_ff <= 7'h01;
         {pa_ff, ax_ff, evt_ff, gap_ff} <= '0;
      end else begin
         pa_ff  <= pulse_a_i;
         ax_ff  <= aux_pulse_i;
         evt_ff <= evt ? 4'hf : evt_ff - 4'(evt_ff != 4'h0);
         gap_ff <= evt ? 32'h0 : gap_ff + 32'(gap_ff != 32'hffffffff);
         if (wr_i && addr_i == REG_THRESH) thr_ff <= wdata_i;
         if (wr_i && addr_i == REG_CMD && wdata_i[CMD_RESET]) ctl_ff <= 7'h01;
         if (wr_i && addr_i == REG_CTRL) ctl_ff <= wdata_i[6:0] & 7'h77;
      end
   end

   thr_rb_a: assert property ($past(rd_i) && $past(addr_i) == REG_THRESH |-> rdata_o == thr_ff)
      else $error("threshold readback differs");
   ctl_rb_a: assert property ($past(rd_i) && $past(addr_i) == REG_CTRL |->
      (rdata_o & 32'h77) == {25'h0, ctl_ff}) else $error("pending selectors differ");
   idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its cycle");
   unmapped_a: assert property ($past(rd_i) && $past(addr_i) > REG_PHASE |-> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   frac_w_a: assert property ($past(rd_i) && $past(addr_i) == REG_TIME_FRAC |->
      rdata_o[31:26] == 6'h0) else $error("fraction wider than 26 bits");
   status_fmt_a: assert property ($past(rd_i) && $past(addr_i) == REG_STATUS |->
      rdata_o[31:8] == 24'h0 && rdata_o[4:2] <= 3'h4 && !rdata_o[1]) else $error("status format");
   synced_in_a: assert property ($past(rd_i) && $past(addr_i) == REG_STATUS && rdata_o[0]
      |-> rdata_o[4:2] inside {IN_SERIAL, IN_OVER, IN_AUX}) else $error("synced without input");
   lock_cause_a: assert property ($rose(synced_o) |-> evt_ff != 4'h0)
      else $error("lock without reference event");
   window_a: assert property (gap_ff > ONE_SEC + TOL + 16 |-> !synced_o)
      else $error("synced after missed window");
endmodule // tscsm_chk

bind tscsm_top tscsm_chk #(.ONE_SEC(ONE_SEC), .TOL(TOL)) u_chk (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .pulse_a_i(pulse_a_i), .aux_pulse_i(aux_pulse_i),
   .sync_a_o(sync_a_o), .sync_a_oe_o(sync_a_oe_o), .synced_o(synced_o));

// File: tb/tscsm_top_tb.sv
// Purpose: Self-checking bench for the clock sync unit.
// Assumes: Shortened pulse window; one reference second is 2000 cycles.
// Notes:   Boundaries are forced by loading a fraction just short of a wrap.
`timescale 1ns/10ps
module tscsm_top_tb;
   import tscsm_pkg::*;
   localparam int unsigned ONE_SEC = 2000;
   localparam int unsigned TOL     = 100;
   logic        clk_i, arst_n_i, wr_i, rd_i, aux_pulse_i, pps_en, pps_skip, rd_pend;
   logic        pulse_a_i, sync_a_o, sync_a_oe_o, synced_o;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o, hsec;
   logic [63:0] exp_q[$];
   logic [63:0] ent;
   int          n_errors, samples_checked;

   tscsm_top #(.ONE_SEC(ONE_SEC), .TOL(TOL)) uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .pulse_a_i(pulse_a_i), .aux_pulse_i(aux_pulse_i),
      .sync_a_o(sync_a_o), .sync_a_oe_o(sync_a_oe_o), .synced_o(synced_o));
   tscsm_pps_src #(.PERIOD(ONE_SEC), .WIDTH(10)) u_src (
      .clk_i(clk_i), .en_i(pps_en), .skip_i(pps_skip), .pulse_o(pulse_a_i));

   // Free-running 50 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask

   // The expectation is queued before the strobe so the watcher always finds it.
   task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      exp_q.push_back({m, e & m});
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
   endtask

   // Settles first, so a zero bound is a plain check of a settled level.
   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      int k;
      #1;
      for (k = 0; k < lim && s !== v; k++) begin
         @(posedge clk_i);
         #1;
      end
      check({31'h0, s}, {31'h0, v});
      if (s !== v) report_and_stop();
   endtask

   task automatic next_pulse();
      wait_lvl(pulse_a_i, 1'b0, ONE_SEC);
      wait_lvl(pulse_a_i, 1'b1, ONE_SEC);
   endtask

   // Full reset, new selectors, then a set that brings the next boundary close.
   task automatic apply(input logic [31:0] c);
      wreg(REG_CMD, 32'h2);
      wreg(REG_CTRL, c);
      wait_lvl(sync_a_oe_o, 1'b0, 0);
      rreg(REG_STATUS, 32'hfe, 32'h04);
      wreg(REG_HOST_FRAC, 32'h3ffff00);
      wreg(REG_CMD, 32'h1);
      wait_lvl(sync_a_oe_o, 1'b1, 400);
      rreg(REG_STATUS, 32'hfe, {24'h0, c[6:4], c[2:0], 2'b0});
   endtask

   // Each read result is judged while it stands, oldest expectation first.
   always @(posedge clk_i) rd_pend <= rd_i;
   always @(negedge clk_i) begin
      if (rd_pend === 1'b1) begin
         ent = exp_q.pop_front();
         check(rdata_o & ent[63:32], ent[31:0]);
      end
   end

   // Main sequence.
   initial begin
      {arst_n_i, wr_i, rd_i, aux_pulse_i, pps_en, pps_skip} = '0;
      addr_i = 8'h0;
      wdata_i = 32'h0;
      n_errors = 0;
      samples_checked = 0;
      hsec = $urandom(32'h0f4f7035);
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rreg(REG_CTRL, 32'h77, 32'h01);
      rreg(REG_STATUS, 32'hff, 32'h04);
      rreg(REG_THRESH, '1, 32'd596);
      rreg(8'h40, '1, 32'h0);
      wait_lvl(sync_a_oe_o, 1'b0, 0);
      // A wide threshold keeps lock possible with the shortened second.
      wreg(REG_THRESH, {8'h01, hsec[23:0]});
      rreg(REG_THRESH, '1, {8'h01, hsec[23:0]});
      wreg(REG_HOST_SEC, hsec);
      wreg(REG_CMD, 32'h1);
      rreg(REG_TIME_SEC, '1, hsec);
      rreg(REG_CTRL, 32'h77, 32'h01);
      $display("test reset_and_set done");
      apply(32'h43);
      wait_lvl(sync_a_o, 1'b1, 0);
      rreg(REG_TIME_SEC, '1, hsec + 32'h1);
      wreg(REG_CORR, 32'h0);
      wait_lvl(synced_o, 1'b1, 8);
      rreg(REG_TOTAL, '1, 32'h1);
      $display("test master_hostref done");
      apply(32'h24);
      @(posedge clk_i);
      aux_pulse_i <= 1'b1;
      wait_lvl(sync_a_o, 1'b1, 12);
      @(posedge clk_i);
      aux_pulse_i <= 1'b0;
      wait_lvl(sync_a_o, 1'b0, 12);
      $display("test loop_aux done");
      apply(32'h11);
      @(posedge clk_i);
      pps_en <= 1'b1;
      wait_lvl(pulse_a_i, 1'b1, 4);
      wait_lvl(sync_a_o, 1'b1, 8);
      wait_lvl(synced_o, 1'b1, 8);
      wreg(REG_CMD, 32'h4);
      next_pulse();
      next_pulse();
      wait_lvl(pulse_a_i, 1'b0, 20);
      @(posedge clk_i);
      pps_skip <= 1'b1;
      wait_lvl(synced_o, 1'b0, ONE_SEC + TOL + 40);
      @(posedge clk_i);
      pps_skip <= 1'b0;
      next_pulse();
      wait_lvl(synced_o, 1'b1, 8);
      rreg(REG_TOTAL, '1, 32'h3);
      rreg(REG_MISSED, '1, 32'h1);
      rreg(REG_LONGEST, '1, 32'h1);
      rreg(REG_BAD, '1, 32'h0);
      rreg(REG_RESYNCS, '1, 32'h1);
      $display("test repeat_and_stats done");
      for (int k = 0; k < 4 && exp_q.size() != 0; k++) @(posedge clk_i);
      if (exp_q.size() != 0) n_errors++;
      report_and_stop();
   end
endmodule // tscsm_top_tb
